/* File: rtl/cic_pkg.sv */
/*
  constants, register map and state type for the core interrupt control block.
  assumes a single 40 MHz clock and an APB master with 32-bit data.
*/
package cic_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  // instruction_cycle_time, in ns
  localparam int unsigned TCY_NS = 100;
  localparam int unsigned QUARTERS_PER_TCY = TCY_NS / CLK_PERIOD_NS;
  // whole instruction cycles from the first_quarter_phase sample to service start
  localparam int unsigned SERVICE_DELAY_TCY = 3;

  localparam logic [1:0] QPH_FIRST = 2'h0;
  localparam logic [1:0] QPH_STEP = 2'h1;
  localparam logic [1:0] QPH_FOURTH = 2'(QUARTERS_PER_TCY - 1);
  localparam logic [1:0] DLY_ZERO = 2'h0;
  localparam logic [1:0] DLY_STEP = 2'h1;
  localparam logic [1:0] DLY_LAST = 2'(SERVICE_DELAY_TCY - 1);

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PINS = 8'h04;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h0c;

  // irq_control_reg bit positions
  localparam int unsigned CTRL_GLOBAL_EN = 7;
  localparam int unsigned CTRL_PERIPH_EN = 6;
  localparam int unsigned CTRL_T0_EN = 5;
  localparam int unsigned CTRL_EXT_EN = 4;
  localparam int unsigned CTRL_PC_EN = 3;
  localparam int unsigned CTRL_T0_FLAG = 2;
  localparam int unsigned CTRL_EXT_FLAG = 1;
  localparam int unsigned CTRL_PC_FLAG = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_STORE_MASK = 8'hfe;

  // per_pin_change_flags
  localparam int unsigned NUM_PINS = 6;
  localparam logic [7:0] PINS_MASK = 8'h3f;

  // event status and mask bit positions
  localparam int unsigned EVT_T0 = 0;
  localparam int unsigned EVT_EXT = 1;
  localparam int unsigned EVT_PC = 2;
  localparam int unsigned EVT_SVC = 3;
  localparam logic [7:0] EVT_VALID = 8'h0f;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [23:0] PAD_ZERO = 24'h00_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic {
    CIC_IDLE,
    CIC_COUNT
  } cic_state_t;

endpackage

/* File: rtl/cic_sync3.sv */
/*
  three-stage synchroniser with agreement filter for one pin.
  assumes the pin is asynchronous to ref_clk; rstn is synchronous.
*/
module cic_sync3
  import cic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic level,
  output logic rise
);

  // ************************************************************
  // stages
  // ************************************************************
  logic meta;
  logic stage2;
  logic stage3;
  logic next_level;

  // only stage2 looks at the metastable flop
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  // a change counts once two settled stages agree
  assign next_level = (stage2 == stage3) ? stage3 : level;
  assign rise = next_level & ~level;

endmodule

/* File: rtl/cic_core_irq_ctrl.sv */
/*
  core interrupt control: irq_control_reg, pin-change flags, event status,
  quarter-phase sequencing and the request towards the processor core.
  assumes an APB master on ref_clk, timer and pin-change events as one-cycle
  pulses from logic on ref_clk, and the external interrupt as a raw pin.
*/
// Added by the designer: the register addresses and register access over APB.
// Summary of operation
// - flags set regardless of any enable
// - peripheral requests need peripheral group enable
// - summary flag read-only, OR of pin flags
// - external flag sampled at each first quarter
// - asynchronous event latency three to five cycles
// - synchronous event latency three to four cycles
// - latency independent of instruction length
// - external flag set in fourth-to-first quarter
module cic_core_irq_ctrl
  import cic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_pin,
  input wire logic timer_zero_overflow,
  input wire logic [NUM_PINS-1:0] pin_change_events,
  input wire logic periph_irq_req,
  output logic irq,
  output logic core_irq_pending,
  output logic irq_service_start,
  output logic [1:0] quarter_phase
);

  // ************************************************************
  // helpers
  // ************************************************************
  // sticky update where a hardware set beats a same-cycle clear
  function automatic logic [7:0] set_wins(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic [7:0] clr
  );
    return (cur & ~clr) | set;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] irq_control_reg;
  logic [7:0] per_pin_change_flags;
  logic [7:0] evt_status;
  logic [7:0] evt_mask;
  logic ext_hold;
  cic_state_t state;
  logic [1:0] dly_cnt;

  logic [7:0] next_ctrl;
  logic [7:0] next_pins;
  logic [7:0] next_status;
  logic [7:0] next_mask;
  logic next_ext_hold;
  cic_state_t next_state;
  logic [1:0] next_dly_cnt;
  logic [1:0] next_phase;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_irq;

  // ************************************************************
  // quarter phases
  // ************************************************************
  wire logic first_quarter_phase;
  wire logic fourth_quarter_phase;
  wire logic ext_window;

  assign first_quarter_phase = quarter_phase == QPH_FIRST;
  assign fourth_quarter_phase = quarter_phase == QPH_FOURTH;
  assign ext_window = first_quarter_phase | fourth_quarter_phase;
  // phases run from reset on, whether or not a request is waiting
  assign next_phase = fourth_quarter_phase ? QPH_FIRST : quarter_phase + QPH_STEP;

  // ************************************************************
  // external pin
  // ************************************************************
  wire logic ext_rise;
  wire logic ext_set;

  cic_sync3 u_ext_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(ext_pin),
    .level(),
    .rise(ext_rise)
  );

  // rising edges only; a pin held high raises one event
  // an edge outside the window waits for the next fourth quarter
  assign ext_set = ext_window & (ext_rise | ext_hold);
  assign next_ext_hold = (ext_hold | ext_rise) & ~ext_window;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire logic apb_setup;
  wire logic apb_access;
  wire logic wr_en;
  wire logic sel_ctrl;
  wire logic sel_pins;
  wire logic sel_status;
  wire logic sel_mask;
  wire logic addr_hit;
  wire logic wr_ctrl;
  wire logic wr_pins;
  wire logic wr_status;
  wire logic wr_mask;
  wire logic [7:0] wbyte;

  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  // registers are one byte wide, so only lane 0 carries a write
  assign wr_en = apb_access & pwrite & pstrb[0];
  assign wbyte = pwdata[7:0];
  assign sel_ctrl = paddr == ADDR_CTRL;
  assign sel_pins = paddr == ADDR_PINS;
  assign sel_status = paddr == ADDR_EVT_STATUS;
  assign sel_mask = paddr == ADDR_EVT_MASK;
  assign addr_hit = sel_ctrl | sel_pins | sel_status | sel_mask;
  assign wr_ctrl = wr_en & sel_ctrl;
  assign wr_pins = wr_en & sel_pins;
  assign wr_status = wr_en & sel_status;
  assign wr_mask = wr_en & sel_mask;

  // zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;

  // ************************************************************
  // flags and enables
  // ************************************************************
  wire logic pc_summary;
  wire logic [7:0] ctrl_view;
  wire logic [7:0] ctrl_base;
  wire logic [7:0] ctrl_hw_set;
  wire logic [7:0] ctrl_hw_clr;
  wire logic [7:0] pins_set;
  wire logic [7:0] pins_clr;
  wire logic svc_fire;
  wire logic [7:0] pin_events_wide;
  wire logic pin_event_any;

  assign pc_summary = |per_pin_change_flags;
  assign ctrl_view = {irq_control_reg[7:1], pc_summary};
  // writes to the summary bit are dropped by the store mask
  assign ctrl_base = (wr_ctrl ? wbyte : irq_control_reg) & CTRL_STORE_MASK;
  // flags set whatever the enables say
  assign ctrl_hw_set = (8'(timer_zero_overflow) << CTRL_T0_FLAG)
                     | (8'(ext_set) << CTRL_EXT_FLAG);
  // vectoring drops the global enable so the core is not re-entered
  assign ctrl_hw_clr = 8'(svc_fire) << CTRL_GLOBAL_EN;
  assign next_ctrl = set_wins(ctrl_base, ctrl_hw_set, ctrl_hw_clr);

  // pin flags clear by writing zero; a new change beats the clear
  assign pin_events_wide = 8'(pin_change_events);
  assign pin_event_any = |pin_change_events;
  assign pins_set = pin_events_wide;
  assign pins_clr = wr_pins ? ~wbyte : BYTE_ZERO;
  assign next_pins = set_wins(per_pin_change_flags, pins_set, pins_clr) & PINS_MASK;

  // ************************************************************
  // request path
  // ************************************************************
  wire logic t0_req;
  wire logic ext_req;
  wire logic pc_req;
  wire logic periph_req;
  wire logic pend_now;
  wire logic dly_done;

  assign t0_req = irq_control_reg[CTRL_T0_EN] & irq_control_reg[CTRL_T0_FLAG];
  assign ext_req = irq_control_reg[CTRL_EXT_EN] & irq_control_reg[CTRL_EXT_FLAG];
  assign pc_req = irq_control_reg[CTRL_PC_EN] & pc_summary;
  assign periph_req = irq_control_reg[CTRL_PERIPH_EN] & periph_irq_req;
  assign pend_now = irq_control_reg[CTRL_GLOBAL_EN]
                  & (t0_req | ext_req | pc_req | periph_req);
  assign dly_done = dly_cnt == DLY_LAST;
  // counted in first quarters only, so instruction length cannot matter
  assign svc_fire = (state == CIC_COUNT) & first_quarter_phase & pend_now & dly_done;

  // a request that drops at a first quarter aborts; no late start
  // sample at each first quarter, then wait whole instruction cycles
  always_comb begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    unique case (state)
      CIC_IDLE: begin
        if (first_quarter_phase & pend_now) begin
          next_state = CIC_COUNT;
          next_dly_cnt = DLY_ZERO;
        end
      end
      CIC_COUNT: begin
        if (first_quarter_phase) begin
          if (!pend_now || dly_done) begin
            next_state = CIC_IDLE;
          end else begin
            next_dly_cnt = dly_cnt + DLY_STEP;
          end
        end
      end
    endcase
  end

  // ************************************************************
  // event status and interrupt
  // ************************************************************
  wire logic [7:0] evt_set;
  wire logic [7:0] evt_clr;

  assign evt_set = (8'(timer_zero_overflow) << EVT_T0)
                 | (8'(ext_set) << EVT_EXT)
                 | (8'(pin_event_any) << EVT_PC)
                 | (8'(svc_fire) << EVT_SVC);
  assign evt_clr = wr_status ? wbyte : BYTE_ZERO;
  assign next_status = set_wins(evt_status, evt_set, evt_clr) & EVT_VALID;
  assign next_mask = (wr_mask ? wbyte : evt_mask) & EVT_VALID;
  assign next_irq = |(next_status & next_mask);

  // ************************************************************
  // read path
  // ************************************************************
  // reads have no side effects, so polling the flags is safe
  logic [7:0] read_byte;

  always_comb begin
    read_byte = BYTE_ZERO;
    if (sel_ctrl) begin
      read_byte = ctrl_view;
    end else if (sel_pins) begin
      read_byte = per_pin_change_flags;
    end else if (sel_status) begin
      read_byte = evt_status;
    end else if (sel_mask) begin
      read_byte = evt_mask;
    end
  end

  assign next_prdata = (apb_setup & ~pwrite) ? {PAD_ZERO, read_byte} : WORD_ZERO;
  assign next_pslverr = apb_setup & ~addr_hit;

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_control_reg <= CTRL_RESET;
      per_pin_change_flags <= BYTE_ZERO;
      evt_status <= BYTE_ZERO;
      evt_mask <= BYTE_ZERO;
      ext_hold <= 1'b0;
      quarter_phase <= QPH_FIRST;
    end else begin
      irq_control_reg <= next_ctrl;
      per_pin_change_flags <= next_pins;
      evt_status <= next_status;
      evt_mask <= next_mask;
      ext_hold <= next_ext_hold;
      quarter_phase <= next_phase;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= CIC_IDLE;
      dly_cnt <= DLY_ZERO;
      core_irq_pending <= 1'b0;
      irq_service_start <= 1'b0;
    end else begin
      state <= next_state;
      dly_cnt <= next_dly_cnt;
      core_irq_pending <= next_state == CIC_COUNT;
      irq_service_start <= svc_fire;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prdata <= WORD_ZERO;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

endmodule

/* File: verification/cic_core_irq_ctrl_chk.sv */
/*
  port assertions for the core interrupt control block.
  assumes one ref_clk domain and synchronous active-low rstn.
*/
module cic_core_irq_ctrl_chk
  import cic_pkg::*;
(
  input logic ref_clk,
  input logic rstn,
  input logic psel,
  input logic penable,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic core_irq_pending,
  input logic irq_service_start,
  input logic [1:0] quarter_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bus and sequencer checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire acc = psel && penable;
  wire unm = !(paddr inside {ADDR_CTRL, ADDR_PINS, ADDR_EVT_STATUS, ADDR_EVT_MASK});

  ready_const_a: assert property (pready) else $error("pready low");
  err_map_a: assert property (acc |-> pslverr == unm) else $error("pslverr wrong");
  idle_quiet_a: assert property (!acc |-> prdata == WORD_ZERO && !pslverr)
    else $error("bus not quiet");
  upper_zero_a: assert property (prdata[31:8] == PAD_ZERO) else $error("upper bits set");
  pend_phase_a: assert property ($rose(core_irq_pending) |-> quarter_phase == 2'h1)
    else $error("pending off phase");
  // exact figure: twelve clocks of pending, then the pulse
  svc_lat_a: assert property (irq_service_start |-> $past(core_irq_pending, 12)
    && !$past(core_irq_pending, 13) && !core_irq_pending) else $error("service latency wrong");
  svc_pulse_a: assert property (irq_service_start |=> !irq_service_start)
    else $error("start too long");
  svc_phase_a: assert property (irq_service_start |-> quarter_phase == 2'h1)
    else $error("start off phase");
  phase_wrap_a: assert property (quarter_phase == 2'h3 |=> quarter_phase == 2'h0)
    else $error("phase wrap wrong");
endmodule

bind cic_core_irq_ctrl cic_core_irq_ctrl_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_irq_pending(core_irq_pending), .irq_service_start(irq_service_start),
  .quarter_phase(quarter_phase));

/* File: verification/cic_core_seq.sv */
/*
  processor core model: counts service starts from the block.
  assumes one ref_clk domain and synchronous active-low rstn.
*/
module cic_core_seq (
  input logic ref_clk,
  input logic rstn,
  input logic irq_service_start,
  output logic [7:0] svc_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // vector entry
  // ****
  // counting only, so a missed or extra start shows in the bench
  always_ff @(posedge ref_clk) begin
    if (!rstn) svc_count <= 8'h00;
    else if (irq_service_start) svc_count <= svc_count + 8'h01;
  end
endmodule

/* File: verification/tb.sv */
/*
  self-checking bench for the core interrupt control block.
  assumes design, checker and core model are compiled first.
*/
module tb
  import cic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_pin = 1'b0, timer_zero_overflow = 1'b0, periph_irq_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [NUM_PINS-1:0] pin_change_events = '0;
  logic pready, pslverr, irq, core_irq_pending, irq_service_start, rerr;
  logic [1:0] quarter_phase;
  logic [7:0] svc_count, base;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x;} cic_row_t;
  // bit 0 of the control register ignores writes
  cic_row_t rows [6] = '{'{ADDR_CTRL, 32'hffff_ffff, 32'h0000_00fe}, '{ADDR_CTRL, 32'h0000_0000, 32'h0000_0000},
    '{ADDR_EVT_MASK, 32'hffff_ffff, 32'h0000_000f}, '{ADDR_EVT_MASK, 32'h0000_0000, 32'h0000_0000},
    '{ADDR_PINS, 32'h0000_0000, 32'h0000_0000}, '{8'h10, 32'hffff_ffff, 32'h0000_0000}};

  always #12.5 ref_clk = ~ref_clk;

  cic_core_irq_ctrl i_cic_core_irq_ctrl (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pin(ext_pin), .timer_zero_overflow(timer_zero_overflow),
    .pin_change_events(pin_change_events), .periph_irq_req(periph_irq_req), .irq(irq),
    .core_irq_pending(core_irq_pending), .irq_service_start(irq_service_start),
    .quarter_phase(quarter_phase));
  cic_core_seq i_cic_core_seq (.ref_clk(ref_clk), .rstn(rstn), .irq_service_start(irq_service_start),
    .svc_count(svc_count));

  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so back-to-back calls never drive psel twice at once
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0000_0000);
    chk(n, rdat, x);
  endtask
  // kind 0 timer, 1 pin, 2 none; counts clocks until the start pulse
  task automatic lat(input int k, input int lo, input int hi);
    int n;
    n = 0;
    if (k == 0) timer_zero_overflow <= 1'b1;
    else if (k == 1) ext_pin <= 1'b1;
    do begin
      @(posedge ref_clk);
      timer_zero_overflow <= 1'b0;
      n++;
    end while (irq_service_start !== 1'b1 && n < 40);
    chk("latency", 32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****
  // sequence
  // ****
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd("ctrl", ADDR_CTRL, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd("row", rows[i].a, rows[i].x);
      chk("err", rerr, 32'(rows[i].a == 8'h10));
    end
    // lane 0 off: the write must be dropped
    pstrb <= 4'he;
    wr(ADDR_CTRL, 32'h0000_0038);
    pstrb <= 4'hf;
    rd("strb", ADDR_CTRL, 32'h0000_0000);
    // reset in mid-run clears what software set
    wr(ADDR_CTRL, 32'h0000_0038);
    wr(ADDR_EVT_MASK, 32'h0000_000f);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd("ctrl", ADDR_CTRL, 32'h0000_0000);
    rd("mask", ADDR_EVT_MASK, 32'h0000_0000);
    wr(ADDR_EVT_STATUS, 32'h0000_00ff);
    timer_zero_overflow <= 1'b1;
    pin_change_events <= 6'h04;
    @(posedge ref_clk);
    timer_zero_overflow <= 1'b0;
    pin_change_events <= 6'h00;
    rd("ctrl", ADDR_CTRL, 32'h0000_0005);
    rd("stat", ADDR_EVT_STATUS, 32'h0000_0005);
    chk("irq", irq, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001);
    rd("ctrl", ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_PINS, 32'h0000_003b);
    rd("ctrl", ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_EVT_MASK, 32'h0000_0004);
    repeat (2) @(posedge ref_clk);
    chk("irq", irq, 32'h0000_0001);
    wr(ADDR_EVT_STATUS, 32'h0000_0004);
    repeat (2) @(posedge ref_clk);
    chk("irq", irq, 32'h0000_0000);
    // source enabled but global enable off: no start within the limit
    base = svc_count;
    wr(ADDR_CTRL, 32'h0000_0020);
    lat(0, 40, 40);
    rd("ctrl", ADDR_CTRL, 32'h0000_0024);
    chk("svc", svc_count, base);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_00a0);
      repeat (k) @(posedge ref_clk);
      lat(0, 13, 17);
    end
    rd("ctrl", ADDR_CTRL, 32'h0000_0024);
    repeat (20) @(posedge ref_clk);
    chk("svc", svc_count, base + 8'h04);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0090);
    lat(1, 13, 21);
    rd("ctrl", ADDR_CTRL, 32'h0000_0012);
    ext_pin <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0080);
    periph_irq_req <= 1'b1;
    base = svc_count;
    repeat (20) @(posedge ref_clk);
    chk("svc", svc_count, base);
    wr(ADDR_CTRL, 32'h0000_00c0);
    lat(2, 1, 20);
    periph_irq_req <= 1'b0;
    finish_test;
  end
endmodule
